// [rtl/i2cw_cond.sv]
// Finds SCL edges and START and STOP conditions on synchronised lines.
// Assumes both inputs come from two-flop synchronisers on mclk.
`timescale 1ns/10ps
module i2cw_cond
	import i2cw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_s,
	input wire logic sda_s,
	output i2cw_ev_t ev
);
	logic scl_d_reg;
	logic sda_d_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	always_comb begin
		ev.scl_rise = scl_s & ~scl_d_reg;
		ev.scl_fall = ~scl_s & scl_d_reg;
		ev.start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
		ev.stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
		ev.sda = sda_s;
	end
endmodule : i2cw_cond

// [rtl/i2cw_pkg.sv]
// Types shared by the paged register write slave.
// Assumes the constants header is on the include path.
`include "i2cw_regs.svh"
package i2cw_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] data;
	} i2cw_wr_t;
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} i2cw_ev_t;
	typedef enum logic [3:0] {
		I2CW_IDLE = 4'h1,
		I2CW_RECV = 4'h2,
		I2CW_ACK = 4'h4,
		I2CW_IGNORE = 4'h8
	} i2cw_state_t;
endpackage : i2cw_pkg

// [rtl/i2cw_regs.svh]
// Constants for the paged register write slave.
// Assumes inclusion by the package and the slave module.
`ifndef I2CW_REGS_SVH
`define I2CW_REGS_SVH
`define I2CW_DEV_ADDR 7'h30
`define I2CW_DIR_WRITE 1'b0
`define I2CW_BITS_PER_BYTE 4'h8
`define I2CW_ACK_SLOT 4'h8
`define I2CW_LAST_BIT 4'h7
`define I2CW_BYTE_DEV 3'h0
`define I2CW_BYTE_AHI 3'h1
`define I2CW_BYTE_ALO 3'h2
`define I2CW_BYTE_D0 3'h3
`define I2CW_BYTE_D1 3'h4
`define I2CW_BYTE_D2 3'h5
`define I2CW_BYTE_D3 3'h6
`define I2CW_BYTE_DONE 3'h7
`define I2CW_SCL_MAX_KHZ 400
`endif

// [rtl/i2cw_slave.sv]
// Paged register write slave on a two-wire serial bus.
// Assumes SCL and SDA are pins sampled by mclk, far slower than mclk.
`timescale 1ns/10ps
`include "i2cw_regs.svh"
module i2cw_slave
	import i2cw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output i2cw_wr_t wr,
	output logic wr_stb
);
	logic scl_s;
	logic sda_s;
	i2cw_ev_t ev;
	i2cw_state_t state_reg;
	logic [3:0] bit_reg;
	logic [2:0] byte_reg;
	logic [7:0] shift_reg;
	logic [15:0] addr_reg;
	logic [31:0] data_reg;
	logic full_reg;

	function automatic logic [7:0] shift_in(input logic [7:0] cur,
		input logic b);
		shift_in = {cur[6:0], b};
	endfunction : shift_in

	i2cw_sync #(.INIT(1'b1)) u_sync_scl (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(scl_i),
		.dout(scl_s)
	);
	i2cw_sync #(.INIT(1'b1)) u_sync_sda (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(sda_i),
		.dout(sda_s)
	);
	i2cw_cond u_cond (
		.mclk(mclk),
		.rst_n(rst_n),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.ev(ev)
	);

	logic [7:0] byte_now;
	assign byte_now = shift_in(shift_reg, ev.sda);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= I2CW_IDLE;
			bit_reg <= 4'h0;
			byte_reg <= `I2CW_BYTE_DEV;
		end else if (ev.start) begin
			state_reg <= I2CW_RECV;
			bit_reg <= 4'h0;
			byte_reg <= `I2CW_BYTE_DEV;
		end else if (ev.stop) begin
			state_reg <= I2CW_IDLE;
		end else begin
			case (state_reg)
			I2CW_RECV: begin
				if (ev.scl_rise) begin
					bit_reg <= bit_reg + 4'h1;
				end
				if (ev.scl_fall && bit_reg == `I2CW_BITS_PER_BYTE) begin
					if (byte_reg == `I2CW_BYTE_DEV &&
						shift_reg != {`I2CW_DEV_ADDR, `I2CW_DIR_WRITE}) begin
						state_reg <= I2CW_IGNORE;
					end else if (byte_reg == `I2CW_BYTE_DONE) begin
						// bytes past the seventh are refused
						state_reg <= I2CW_IGNORE;
					end else begin
						state_reg <= I2CW_ACK;
					end
				end
			end
			I2CW_ACK: begin
				if (ev.scl_fall) begin
					state_reg <= I2CW_RECV;
					bit_reg <= 4'h0;
					byte_reg <= byte_reg + 3'h1;
				end
			end
			I2CW_IGNORE: begin
				state_reg <= I2CW_IGNORE;
			end
			default: begin
				state_reg <= I2CW_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= 8'h00;
		end else if (state_reg == I2CW_RECV && ev.scl_rise &&
			bit_reg < `I2CW_BITS_PER_BYTE) begin
			shift_reg <= byte_now;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= 16'h0000;
			data_reg <= 32'h00000000;
			full_reg <= 1'b0;
		end else if (ev.start) begin
			full_reg <= 1'b0;
		end else if (state_reg == I2CW_ACK && ev.scl_fall) begin
			case (byte_reg)
			`I2CW_BYTE_AHI: addr_reg[15:8] <= shift_reg;
			`I2CW_BYTE_ALO: addr_reg[7:0] <= shift_reg;
			`I2CW_BYTE_D0: data_reg[7:0] <= shift_reg;
			`I2CW_BYTE_D1: data_reg[15:8] <= shift_reg;
			`I2CW_BYTE_D2: data_reg[23:16] <= shift_reg;
			`I2CW_BYTE_D3: begin
				data_reg[31:24] <= shift_reg;
				full_reg <= 1'b1;
			end
			default: begin
				full_reg <= full_reg;
			end
			endcase
		end
	end

	// single write at STOP after full frame
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_stb <= 1'b0;
			wr <= '0;
		end else begin
			wr_stb <= ev.stop && full_reg;
			if (ev.stop && full_reg) begin
				wr.addr <= addr_reg;
				wr.data <= data_reg;
			end
		end
	end

	// pull SDA low in ack clock
	// open drain, output level is always low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			sda_oe <= (state_reg == I2CW_ACK) && !ev.scl_fall &&
				!ev.stop && !ev.start;
		end
	end

	// The ack drive must end with the ack clock, else the bus locks.
	// ack held only in ack state
	a_ack_in_slot: assert property (@(posedge mclk) disable iff (!rst_n)
		sda_oe |-> $past(state_reg) == I2CW_ACK)
		else $error("sda driven outside ack slot");
	a_drive_low_only: assert property (@(posedge mclk) disable iff (!rst_n)
		sda_oe |-> !sda_o)
		else $error("sda driven high");
	a_addr_filter: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == I2CW_RECV && byte_reg == `I2CW_BYTE_DEV &&
		ev.scl_fall && bit_reg == `I2CW_BITS_PER_BYTE &&
		shift_reg != {`I2CW_DEV_ADDR, `I2CW_DIR_WRITE} && !ev.start &&
		!ev.stop) |=> state_reg == I2CW_IGNORE)
		else $error("foreign address accepted");
	a_addr_ack: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == I2CW_RECV && byte_reg == `I2CW_BYTE_DEV &&
		ev.scl_fall && bit_reg == `I2CW_BITS_PER_BYTE &&
		shift_reg == {`I2CW_DEV_ADDR, `I2CW_DIR_WRITE} && !ev.start &&
		!ev.stop) |=> ##1 sda_oe)
		else $error("matching address not acknowledged");
	a_strobe_full: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_stb |-> $past(full_reg) && $past(ev.stop))
		else $error("write without four data bytes");
	// no strobe without a full frame
	a_short_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
		(ev.stop && !full_reg) |=> !wr_stb)
		else $error("short frame wrote register");
	a_start_frame: assert property (@(posedge mclk) disable iff (!rst_n)
		ev.start |=> state_reg == I2CW_RECV && byte_reg == `I2CW_BYTE_DEV
		&& bit_reg == 4'h0)
		else $error("start did not reset framing");
	a_data_order: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == I2CW_ACK && ev.scl_fall && !ev.start && !ev.stop &&
		byte_reg == `I2CW_BYTE_D3) |=> data_reg[31:24] == $past(shift_reg)
		&& full_reg)
		else $error("data byte misplaced");
	a_addr_order: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == I2CW_ACK && ev.scl_fall && !ev.start && !ev.stop &&
		byte_reg == `I2CW_BYTE_AHI) |=> addr_reg[15:8] == $past(shift_reg))
		else $error("address high byte misplaced");
	a_sample_rise: assert property (@(posedge mclk) disable iff (!rst_n)
		(shift_reg != $past(shift_reg)) |-> $past(ev.scl_rise))
		else $error("bit sampled off rising edge");
	a_seven_bytes: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == I2CW_RECV && byte_reg == `I2CW_BYTE_DONE &&
		ev.scl_fall && bit_reg == `I2CW_BITS_PER_BYTE && !ev.start &&
		!ev.stop) |=> state_reg == I2CW_IGNORE)
		else $error("extra byte accepted");
endmodule : i2cw_slave

// [rtl/i2cw_sync.sv]
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/10ps
module i2cw_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic meta_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= INIT;
			dout <= INIT;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule : i2cw_sync

// [test/i2cw_master.sv]
// Bus master model: drives SCL high and low, and pulls SDA low through an open-drain pin.
// Assumes pull-ups on both lines and a 160 ns SCL period.
`timescale 1ns/10ps
module i2cw_master (
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// the 160 ns SCL period is 6.25 MHz, far above the 400 kHz ceiling.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start();
		sda_low = 1'b1;
		#40;
		scl = 1'b0;
		#40;
	endtask : start
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low = !b[i];
			#40;
			scl = 1'b1;
			#80;
			scl = 1'b0;
			#40;
		end
		sda_low = 1'b0;
		#40;
		scl = 1'b1;
		#40;
		ack = !sda;
		#40;
		scl = 1'b0;
		#40;
	endtask : send_byte
	task automatic stop();
		sda_low = 1'b1;
		#40;
		scl = 1'b1;
		#40;
		sda_low = 1'b0;
		#80;
	endtask : stop
endmodule : i2cw_master

// [test/tb_i2cw_slave.sv]
// Self-checking bench for the paged register write slave.
// Assumes the master model drives the bus; SDA has a pull-up.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
$display("wrong value %s expected %h seen %h", nm, exp, got); fails++; end end
module tb_i2cw_slave;
	import i2cw_pkg::*;
	logic mclk, rst_n, scl, sda_low, sda_o, sda_oe, wr_stb, sda;
	i2cw_wr_t wr, wr_seen;
	int fails, comparisons, strobes;
	// The wire is low if either party pulls it, else the pull-up wins.
	assign sda = (sda_oe ? sda_o : 1'b1) & !sda_low;
	i2cw_slave uut (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .wr(wr), .wr_stb(wr_stb));
	i2cw_master m (.sda(sda), .scl(scl), .sda_low(sda_low));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (wr_stb === 1'b1) begin
			strobes++;
			wr_seen = wr;
		end
	end
	task automatic frame(input logic [55:0] b, input int n,
		output logic [6:0] acks);
		logic a;
		acks = '0;
		m.start();
		for (int i = 0; i < n; i++) begin
			m.send_byte(b[55 - 8 * i -: 8], a);
			acks[i] = a;
		end
		m.stop();
		repeat (20) @(posedge mclk);
	endtask : frame
	task automatic full_write(input logic [15:0] ad, input logic [31:0] d);
		logic [6:0] acks;
		int s0;
		s0 = strobes;
		frame({8'h60, ad, d[7:0], d[15:8], d[23:16], d[31:24]}, 7, acks);
		`CHK("acks", 7'h7F, acks)
		`CHK("strobes", s0 + 1, strobes)
		`CHK("wr", {ad, d}, wr_seen)
		`CHK("sda_o", 1'b0, sda_o)
	endtask : full_write
	task automatic foreign_address();
		logic [6:0] acks;
		logic [7:0] heads [3];
		int s0;
		heads = '{8'h62, 8'h61, 8'hE0};
		s0 = strobes;
		foreach (heads[i]) begin
			frame({heads[i], 48'h0500_1122_3344}, 7, acks);
			`CHK("acks", 7'h00, acks)
		end
		`CHK("strobes", s0, strobes)
	endtask : foreign_address
	task automatic short_frames();
		logic [6:0] acks;
		int s0;
		s0 = strobes;
		frame(56'h60_0000_0000_0000, 1, acks);
		`CHK("acks", 7'h01, acks)
		frame(56'h60_0501_5566_7788, 6, acks);
		`CHK("acks", 7'h3F, acks)
		`CHK("strobes", s0, strobes)
	endtask : short_frames
	task automatic extra_byte();
		logic a;
		logic [7:0] b [8];
		logic [7:0] acks;
		b = '{8'h60, 8'h05, 8'h20, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		acks = '0;
		m.start();
		foreach (b[i]) begin
			m.send_byte(b[i], a);
			acks[i] = a;
		end
		m.stop();
		repeat (20) @(posedge mclk);
		`CHK("acks", 8'h7F, acks)
	endtask : extra_byte
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	initial begin
		#500000;
		fails++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		#3;
		full_write(16'h1234, 32'hA1B2C3D4);
		full_write(16'hFFFF, 32'h0000_0000);
		foreign_address();
		short_frames();
		extra_byte();
		full_write(16'h0000, 32'hFFFF_FFFF);
		print_verdict();
	end
endmodule : tb_i2cw_slave
